// File: verif/debug_link_props.sv
`timescale 1ns/100ps
module debug_link_props (
  input wire       i_ref_clk,                // Clock
  input wire       i_rst,                    // Reset
  input wire [3:0] i_reg_addr,               // Offset
  input wire       i_reg_wr,                 // Write
  input wire       i_reg_rd,                 // Read
  input wire [7:0] i_reg_wdata,              // Write data
  input wire [7:0] o_reg_rdata,              // Read data
  input wire       o_interface_enabled,      // Enabled
  input wire [1:0] o_interface_clock_select, // Clock code
  input wire       o_system_clock_request,   // Clock held
  input wire       i_key_nvm,                // Key taken
  input wire       i_nvm_prog_done,          // Done
  input wire       o_key_nvm,                // Key
  input wire       o_key_user_row,           // Key
  input wire       o_system_reset,           // Held reset
  input wire       o_user_row_start          // Start
);
  // ****
  // Register side effects
  // ****
  wire wen = i_reg_wr && o_interface_enabled;
  wire rdo = i_reg_rd && o_interface_enabled;
  wire dis = wen && i_reg_addr == 4'h3 && i_reg_wdata[2];

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  chk_reset_hold: assert property (wen && i_reg_addr == 4'h8 && i_reg_wdata == 8'h59 |=> o_system_reset)
    else $error("held reset missing");
  chk_reset_free: assert property (wen && i_reg_addr == 4'h8 && i_reg_wdata != 8'h59 |=> !o_system_reset)
    else $error("held reset kept");
  chk_reset_read: assert property (rdo && i_reg_addr == 4'h8 |=> o_reg_rdata == {7'h00, $past(o_system_reset)})
    else $error("reset read wrong");
  chk_disable_all: assert property (dis |=> !o_interface_enabled && !o_system_clock_request && !o_system_reset
    && !o_key_nvm && !o_key_user_row) else $error("disable left state");
  chk_enable_defaults: assert property ($rose(o_interface_enabled) |-> o_system_clock_request
    && o_interface_clock_select == 2'h3) else $error("enable defaults wrong");
  chk_clksel_zero: assert property (wen && i_reg_addr == 4'h9 && i_reg_wdata[1:0] == 2'h0
    |=> $stable(o_interface_clock_select)) else $error("clock code 0 taken");
  chk_prog_key_clear: assert property (o_interface_enabled && i_nvm_prog_done && !i_key_nvm |=> !o_key_nvm)
    else $error("key kept");
  chk_row_start_key: assert property (o_user_row_start |-> $past(o_key_user_row))
    else $error("start without key");
endmodule

bind debug_link_system_access debug_link_props i_debug_link_props (.*);

// File: verif/link_partner.sv
`timescale 1ns/100ps
module link_partner (
  input  wire i_tx_active, // Device sends
  input  wire i_tx_bit,    // Device bit
  input  wire i_collide,   // Pull against device
  output wire o_line_level // Line level
);
  // ****
  // Open-drain line
  // ****
  // A low from either party wins; the pull-up holds an idle line high.
  wire dev_low  = i_tx_active && !i_tx_bit;
  wire host_low = i_collide && i_tx_active;
  assign o_line_level = !(dev_low || host_low);
endmodule

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic       i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_interface_enable, i_tx_active, i_tx_bit, collide;
  logic       i_transfer_busy, i_key_user_row, i_key_nvm, i_key_erase, i_nvm_prog_done, i_chip_erase_done;
  logic       i_system_in_reset, i_system_in_sleep, i_nvm_prog_ready, i_user_row_ready, i_device_locked;
  logic       i_crc_busy, i_crc_done, i_crc_failed;
  logic [3:0] i_reg_addr;
  logic [7:0] i_reg_wdata, v;
  wire  [7:0] o_reg_rdata;
  wire  [1:0] o_interface_clock_select;
  wire        o_reg_rvalid, o_interface_enabled, o_link_clock_request, o_interface_clock_en, o_collision;
  wire        o_neg_ack_disable, o_send_neg_ack, o_key_user_row, o_key_nvm, o_key_erase, o_system_reset;
  wire        o_user_row_start, o_system_clock_request, i_line_level;
  int         error_cnt, total_checks, n_col, n_nack, n_start, n_clk, i, k;
  integer     seed = 32'h08E4;

  debug_link_system_access i_debug_link_system_access (.*);
  link_partner i_link_partner (.i_tx_active(i_tx_active), .i_tx_bit(i_tx_bit), .i_collide(collide),
    .o_line_level(i_line_level));

  always #5 i_ref_clk = ~i_ref_clk;

  // Pulse outputs are counted so that no single-cycle pulse is missed.
  always @(posedge i_ref_clk)
  begin
    n_col <= n_col + o_collision;
    n_nack <= n_nack + o_send_neg_ack;
    n_start <= n_start + o_user_row_start;
    n_clk <= n_clk + o_interface_clock_en;
  end

  // ****
  // Helpers
  // ****
  function automatic logic [7:0] crc_exp(input logic [2:0] bdf);
    crc_exp = bdf[1] ? (bdf[0] ? 8'h04 : 8'h02) : {7'h00, bdf[2]};
  endfunction

  function automatic int rate(input logic [1:0] c);
    rate = (c == 2'h1) ? 16 : (c == 2'h2) ? 8 : 4;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask

  task automatic cyc(input int n);
  begin
    repeat (n) @(negedge i_ref_clk);
  end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
  begin
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
    cyc(1);
  end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
  begin
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc(1);
    i_reg_rd = 1'b0;
    check(o_reg_rvalid === 1'b1 ? o_reg_rdata : ~exp, exp);
    cyc(1);
  end
  endtask

  task automatic enable;
  begin
    i_interface_enable = 1'b1;
    cyc(1);
    i_interface_enable = 1'b0;
    for (k = 0; k < 4 && o_interface_enabled !== 1'b1; k++)
      cyc(1);
    if (o_interface_enabled !== 1'b1)
    begin
      error_cnt++;
      results;
    end
  end
  endtask

  task automatic results;
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    {i_ref_clk, i_reg_wr, i_reg_rd, i_interface_enable, i_tx_active, i_tx_bit, collide} = 7'h00;
    {i_transfer_busy, i_key_user_row, i_key_nvm, i_key_erase, i_nvm_prog_done, i_chip_erase_done} = 6'h00;
    {i_system_in_reset, i_system_in_sleep, i_nvm_prog_ready, i_user_row_ready, i_device_locked} = 5'h00;
    {i_crc_busy, i_crc_done, i_crc_failed, i_reg_addr, i_reg_wdata} = 15'h0000;
    {error_cnt, total_checks, n_col, n_nack, n_start, n_clk} = '0;
    i_rst = 1'b1;
    cyc(12);
    i_rst = 1'b0;
    cyc(1);
    check({o_interface_enabled, o_link_clock_request, o_interface_clock_select, 4'h0}, 8'h30);
    enable;
    check({o_link_clock_request, o_system_clock_request, o_interface_clock_select, 4'h0}, 8'hF0);
    rd(4'hA, 8'h01);
    rd(4'h5, 8'h00);
    rd(4'hE, 8'h00);
    $display("end defaults");
    for (i = 1; i < 5; i++)
    begin
      v = {6'h3F, i[1:0]};
      wr(4'h9, v);
      rd(4'h9, (i == 4) ? 8'h03 : {6'h00, v[1:0]});
      k = rate((i == 4) ? 2'h3 : v[1:0]);
      n_clk = 0;
      cyc(100);
      check({7'h00, n_clk >= k - 1 && n_clk <= k + 1}, 8'h01);
    end
    $display("end clock select");
    for (i = 0; i < 3; i++)
    begin
      wr(4'h8, 8'h59);
      check({o_system_reset, o_interface_enabled, 6'h00}, 8'hC0);
      rd(4'h8, 8'h01);
      v = 8'($random(seed));
      wr(4'h8, (v == 8'h59) ? 8'h5A : v);
      rd(4'h8, 8'h00);
      rd(4'hB, 8'h20);
      rd(4'hB, 8'h00);
    end
    $display("end reset request");
    i_transfer_busy = 1'b1;
    n_nack = 0;
    wr(4'h8, 8'h59);
    wr(4'h8, 8'h00);
    check(n_nack[7:0], 8'h01);
    wr(4'h3, 8'hF0);
    rd(4'h3, 8'h10);
    check({7'h00, o_neg_ack_disable}, 8'h01);
    n_nack = 0;
    i_system_in_reset = 1'b1;
    wr(4'h8, 8'h59);
    i_system_in_reset = 1'b0;
    wr(4'h8, 8'h00);
    check(n_nack[7:0], 8'h00);
    i_transfer_busy = 1'b0;
    rd(4'hB, 8'h20);
    $display("end negative acknowledge");
    wr(4'h3, 8'h00);
    {i_tx_active, i_tx_bit, collide} = 3'h7;
    n_col = 0;
    cyc(8);
    check({7'h00, n_col > 3}, 8'h01);
    collide = 1'b0;
    cyc(4);
    n_col = 0;
    cyc(8);
    check(n_col[7:0], 8'h00);
    wr(4'h3, 8'h08);
    collide = 1'b1;
    n_col = 0;
    cyc(8);
    check(n_col[7:0], 8'h00);
    {i_tx_active, collide} = 2'h0;
    $display("end collision");
    wr(4'h3, 8'h00);
    {i_key_user_row, i_key_nvm, i_key_erase} = 3'h7;
    cyc(1);
    {i_key_user_row, i_key_nvm, i_key_erase} = 3'h0;
    rd(4'h7, 8'h38);
    check({5'h00, o_key_user_row, o_key_nvm, o_key_erase}, 8'h07);
    {i_nvm_prog_ready, i_user_row_ready} = 2'h3;
    rd(4'hB, 8'h0C);
    i_nvm_prog_done = 1'b1;
    cyc(1);
    i_nvm_prog_done = 1'b0;
    rd(4'h7, 8'h28);
    wr(4'h8, 8'h59);
    wr(4'h8, 8'h00);
    i_chip_erase_done = 1'b1;
    cyc(1);
    i_chip_erase_done = 1'b0;
    rd(4'h7, 8'h20);
    n_start = 0;
    wr(4'hA, 8'hFE);
    check({n_start[6:0], o_system_clock_request}, 8'h02);
    rd(4'hA, 8'h02);
    $display("end keys");
    wr(4'hA, 8'h01);
    wr(4'h8, 8'h59);
    wr(4'h9, 8'h01);
    wr(4'h3, 8'h04);
    check({o_interface_enabled, o_link_clock_request, o_system_reset, o_key_user_row,
      o_system_clock_request, 3'h0}, 8'h00);
    n_start = 0;
    enable;
    rd(4'h9, 8'h03);
    rd(4'h3, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'hA, 8'h01);
    wr(4'hA, 8'h02);
    check(n_start[7:0], 8'h00);
    rd(4'hA, 8'h00);
    $display("end disable");
    for (i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      {i_system_in_sleep, i_nvm_prog_ready, i_user_row_ready, i_device_locked} = v[3:0];
      {i_crc_busy, i_crc_done, i_crc_failed} = i[2:0];
      cyc(1);
      rd(4'hB, {3'h0, v[3:1], 1'b0, v[0]});
      rd(4'hC, crc_exp(i[2:0]));
    end
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h00);
    $display("end status");
    results;
  end
endmodule

// File: verilog/debug_link_consts.vh
// Contract
// - With neg_ack_disable set, no negative acknowledge when system reset hits a transfer.
// - With collision_detect_disable clear, compare line against own transmitted bits.
// - Writing interface_disable shuts the link, drops clock request, resets the interface.
// - Disabling restores link configuration defaults and invalidates all accepted keys.
// - Key status bits 5, 4, 3 read 1 only while their key is active.
// - The programming key bit clears itself when programming finishes.
// - The chip erase key bit clears itself when chip erase completes.
// - Writing 0x59 to reset request holds system reset; any other value releases it.
// - Reset request reads bit 0 as held reset, all other bits zero.
// - A requested system reset leaves the debug interface itself running.
// - After reset and enable the interface clock is 4 MHz.
// - Writing user_row_final starts user row programming, only with the key accepted.
// - system_clock_request set keeps the system clock running in sleep; zero drops it.
// - Clock request clears on disable and sets automatically on every enable.
// - system_reset_active reads 1 while system is in reset; each read clears it. Here a read while reset is still present leaves it set.
// - system_in_sleep reads 1 while the system is idle or deeper asleep.
// - Programming status bit reads 1 when programming may begin from the link.
// - User row status bit reads 1 when user row programming may begin.
// - Lock status reads 1 while locked, 0 after chip erase clears the lock.
// - CRC status is one-hot: 0 off, 1 busy, 2 good, 4 failed.
// - These registers are reached only over the link, never by the processor.
`ifndef DEBUG_LINK_CONSTS_VH
`define DEBUG_LINK_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_PHY_CTRL_B      4'h3
`define ADDR_KEY_STATUS      4'h7
`define ADDR_RESET_REQUEST   4'h8
`define ADDR_CLOCK_SELECT    4'h9
`define ADDR_SYS_CONTROL     4'hA
`define ADDR_SYS_STATUS      4'hB
`define ADDR_CRC_STATUS      4'hC

// ****************************************
// Field positions
// ****************************************
`define BIT_NEG_ACK_DISABLE  4
`define BIT_COLLISION_DIS    3
`define BIT_INTERFACE_DIS    2
`define BIT_KEY_USER_ROW     5
`define BIT_KEY_NVM          4
`define BIT_KEY_ERASE        3
`define BIT_RESET_HELD       0
`define BIT_USER_ROW_FINAL   1
`define BIT_CLOCK_REQUEST    0
`define BIT_RESET_ACTIVE     5
`define BIT_IN_SLEEP         4
`define BIT_NVM_READY        3
`define BIT_USER_ROW_READY   2
`define BIT_LOCKED           0

// ****************************************
// Values
// ****************************************
`define RESET_SIGNATURE      8'h59
`define CLKSEL_RESERVED      2'h0
`define CLKSEL_16MHZ         2'h1
`define CLKSEL_8MHZ          2'h2
`define CLKSEL_4MHZ          2'h3
`define CRC_OFF              3'h0
`define CRC_BUSY             3'h1
`define CRC_GOOD             3'h2
`define CRC_FAIL             3'h4
`define REF_CLOCK_MHZ        7'h64
`define STEP_16MHZ           7'h10
`define STEP_8MHZ            7'h08
`define STEP_4MHZ            7'h04
`define BYTE_ZERO            8'h00

`endif

// File: verilog/debug_link_system_access.v
`timescale 1ns/100ps
`include "debug_link_consts.vh"

module debug_link_system_access (
  input  wire       i_ref_clk,            // 100 MHz clock
  input  wire       i_rst,                // Synchronous reset, active high
  input  wire [3:0] i_reg_addr,           // Register offset from link access layer
  input  wire       i_reg_wr,             // Register write strobe
  input  wire       i_reg_rd,             // Register read strobe
  input  wire [7:0] i_reg_wdata,          // Register write data
  output reg  [7:0] o_reg_rdata,          // Register read data
  output reg        o_reg_rvalid,         // Read data valid pulse
  input  wire       i_interface_enable,   // Enable event, fuse or high-voltage entry
  output wire       o_interface_enabled,  // Interface out of reset
  output wire       o_link_clock_request, // Interface clock request
  output reg  [1:0] o_interface_clock_select, // Selected interface clock code
  output reg        o_interface_clock_en, // Interface clock enable pulse
  input  wire       i_tx_active,          // Own transmission in progress
  input  wire       i_tx_bit,             // Bit being transmitted
  input  wire       i_line_level,         // One-wire line level pin
  output reg        o_collision,          // Collision detected pulse
  output wire       o_neg_ack_disable,    // Negative acknowledge suppressed
  input  wire       i_transfer_busy,      // Load or store transfer in progress
  output reg        o_send_neg_ack,       // Send negative acknowledge pulse
  input  wire       i_key_user_row,       // User row write key accepted pulse
  input  wire       i_key_nvm,            // Programming key accepted pulse
  input  wire       i_key_erase,          // Chip erase key accepted pulse
  input  wire       i_nvm_prog_done,      // Programming sequence finished pulse
  input  wire       i_chip_erase_done,    // Chip erase finished pulse
  output wire       o_key_user_row,       // User row write key active
  output wire       o_key_nvm,            // Programming key active
  output wire       o_key_erase,          // Chip erase key active
  output wire       o_system_reset,       // Held system reset request
  output reg        o_user_row_start,     // Start user row programming pulse
  output wire       o_system_clock_request, // Keep system clock in sleep
  input  wire       i_system_in_reset,    // System domain in reset
  input  wire       i_system_in_sleep,    // System domain idle or deeper
  input  wire       i_nvm_prog_ready,     // Programming may begin
  input  wire       i_user_row_ready,     // User row programming may begin
  input  wire       i_device_locked,      // Device locked
  input  wire       i_crc_busy,           // CRC running
  input  wire       i_crc_done,           // CRC finished
  input  wire       i_crc_failed          // CRC signature failed
);

  // ****************************************
  // Functions
  // ****************************************
  function [6:0] clock_step;
    input [1:0] sel;
    begin
      case (sel)
        `CLKSEL_16MHZ: clock_step = `STEP_16MHZ;
        `CLKSEL_8MHZ:  clock_step = `STEP_8MHZ;
        default:       clock_step = `STEP_4MHZ;
      endcase
    end
  endfunction

  function is_write;
    input [3:0] addr;
    input [3:0] target;
    begin
      is_write = i_reg_wr && (addr == target);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg       enabled;
  reg       neg_ack_disable;
  reg       collision_detect_disable;
  reg       key_user_row;
  reg       key_nvm;
  reg       key_erase;
  reg       reset_held;
  reg       user_row_final;
  reg       clock_request;
  reg       reset_active;
  reg [2:0] crc_state;
  reg       line_meta;
  reg       line_sync;
  reg       sys_reset_seen;
  reg [6:0] clock_acc;
  reg [7:0] next_rdata;
  reg [2:0] next_crc;
  reg [7:0] acc_sum;

  wire iface_rst;
  wire disable_write;
  wire sys_reset_now;

  // Writing the disable bit resets the interface on the following edge.
  assign disable_write = enabled && is_write(i_reg_addr, `ADDR_PHY_CTRL_B) && i_reg_wdata[`BIT_INTERFACE_DIS];
  assign iface_rst     = i_rst || !enabled;
  assign sys_reset_now = i_system_in_reset || reset_held;

  assign o_interface_enabled    = enabled;
  assign o_link_clock_request   = enabled;
  assign o_neg_ack_disable      = neg_ack_disable;
  assign o_key_user_row         = key_user_row;
  assign o_key_nvm              = key_nvm;
  assign o_key_erase            = key_erase;
  assign o_system_reset         = reset_held;
  assign o_system_clock_request = enabled && clock_request;

  // ****************************************
  // Interface enable and disable
  // ****************************************
  // The interface itself is never reset by the system reset it requests.
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      enabled <= 1'b0;
    else if (disable_write)
      enabled <= 1'b0;
    else if (i_interface_enable)
      enabled <= 1'b1;
  end

  // ****************************************
  // Link configuration
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (iface_rst || disable_write)
    begin
      neg_ack_disable          <= 1'b0;
      collision_detect_disable <= 1'b0;
    end
    else if (is_write(i_reg_addr, `ADDR_PHY_CTRL_B))
    begin
      neg_ack_disable          <= i_reg_wdata[`BIT_NEG_ACK_DISABLE];
      collision_detect_disable <= i_reg_wdata[`BIT_COLLISION_DIS];
    end
  end

  // ****************************************
  // Collision detection
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end
    else
    begin
      line_meta <= i_line_level;
      line_sync <= line_meta;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
      o_collision <= 1'b0;
    else
      o_collision <= i_tx_active && !collision_detect_disable && (line_sync != i_tx_bit);
  end

  // ****************************************
  // Negative acknowledge on system reset
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
    begin
      sys_reset_seen <= 1'b0;
      o_send_neg_ack <= 1'b0;
    end
    else
    begin
      sys_reset_seen <= sys_reset_now;
      o_send_neg_ack <= sys_reset_now && !sys_reset_seen && i_transfer_busy && !neg_ack_disable;
    end
  end

  // ****************************************
  // Access keys
  // ****************************************
  // A new acceptance in the same cycle as completion keeps the key active.
  always @(posedge i_ref_clk)
  begin
    if (iface_rst || disable_write)
    begin
      key_user_row <= 1'b0;
      key_nvm      <= 1'b0;
      key_erase    <= 1'b0;
    end
    else
    begin
      if (i_key_user_row)
        key_user_row <= 1'b1;
      if (i_key_nvm)
        key_nvm <= 1'b1;
      else if (i_nvm_prog_done)
        key_nvm <= 1'b0;
      if (i_key_erase)
        key_erase <= 1'b1;
      else if (i_chip_erase_done)
        key_erase <= 1'b0;
    end
  end

  // ****************************************
  // System reset request
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (iface_rst || disable_write)
      reset_held <= 1'b0;
    else if (is_write(i_reg_addr, `ADDR_RESET_REQUEST))
      reset_held <= (i_reg_wdata == `RESET_SIGNATURE);
  end

  // ****************************************
  // Interface clock select and divider
  // ****************************************
  // The reserved code is ignored so the clock never stops.
  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
      o_interface_clock_select <= `CLKSEL_4MHZ;
    else if (is_write(i_reg_addr, `ADDR_CLOCK_SELECT) && (i_reg_wdata[1:0] != `CLKSEL_RESERVED))
      o_interface_clock_select <= i_reg_wdata[1:0];
  end

  // Fractional accumulator gives the selected mean rate from 100 MHz.
  always @*
  begin
    acc_sum = {1'b0, clock_acc} + {1'b0, clock_step(o_interface_clock_select)};
  end

  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
    begin
      clock_acc            <= 7'h00;
      o_interface_clock_en <= 1'b0;
    end
    else if (acc_sum >= {1'b0, `REF_CLOCK_MHZ})
    begin
      clock_acc            <= acc_sum[6:0] - `REF_CLOCK_MHZ;
      o_interface_clock_en <= 1'b1;
    end
    else
    begin
      clock_acc            <= acc_sum[6:0];
      o_interface_clock_en <= 1'b0;
    end
  end

  // ****************************************
  // System control
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (i_rst || disable_write)
      clock_request <= 1'b0;
    else if (!enabled)
      clock_request <= i_interface_enable;
    else if (is_write(i_reg_addr, `ADDR_SYS_CONTROL))
      clock_request <= i_reg_wdata[`BIT_CLOCK_REQUEST];
  end

  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
    begin
      user_row_final   <= 1'b0;
      o_user_row_start <= 1'b0;
    end
    else if (is_write(i_reg_addr, `ADDR_SYS_CONTROL) && key_user_row)
    begin
      user_row_final   <= i_reg_wdata[`BIT_USER_ROW_FINAL];
      o_user_row_start <= i_reg_wdata[`BIT_USER_ROW_FINAL];
    end
    else
      o_user_row_start <= 1'b0;
  end

  // ****************************************
  // System status
  // ****************************************
  // Reset still present during the clearing read wins over the clear.
  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
      reset_active <= 1'b0;
    else if (sys_reset_now)
      reset_active <= 1'b1;
    else if (i_reg_rd && (i_reg_addr == `ADDR_SYS_STATUS))
      reset_active <= 1'b0;
  end

  always @*
  begin
    next_crc = `CRC_OFF;
    if (i_crc_done)
      next_crc = i_crc_failed ? `CRC_FAIL : `CRC_GOOD;
    else if (i_crc_busy)
      next_crc = `CRC_BUSY;
  end

  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
      crc_state <= `CRC_OFF;
    else
      crc_state <= next_crc;
  end

  // ****************************************
  // Register read
  // ****************************************
  // Only the link access layer reaches this port; there is no processor path.
  always @*
  begin
    next_rdata = `BYTE_ZERO;
    case (i_reg_addr)
      `ADDR_PHY_CTRL_B:
      begin
        next_rdata[`BIT_NEG_ACK_DISABLE] = neg_ack_disable;
        next_rdata[`BIT_COLLISION_DIS]   = collision_detect_disable;
      end
      `ADDR_KEY_STATUS:
      begin
        next_rdata[`BIT_KEY_USER_ROW] = key_user_row;
        next_rdata[`BIT_KEY_NVM]      = key_nvm;
        next_rdata[`BIT_KEY_ERASE]    = key_erase;
      end
      `ADDR_RESET_REQUEST:
        next_rdata[`BIT_RESET_HELD] = reset_held;
      `ADDR_CLOCK_SELECT:
        next_rdata[1:0] = o_interface_clock_select;
      `ADDR_SYS_CONTROL:
      begin
        next_rdata[`BIT_USER_ROW_FINAL] = user_row_final;
        next_rdata[`BIT_CLOCK_REQUEST]  = clock_request;
      end
      `ADDR_SYS_STATUS:
      begin
        next_rdata[`BIT_RESET_ACTIVE]   = reset_active || sys_reset_now;
        next_rdata[`BIT_IN_SLEEP]       = i_system_in_sleep;
        next_rdata[`BIT_NVM_READY]      = i_nvm_prog_ready;
        next_rdata[`BIT_USER_ROW_READY] = i_user_row_ready;
        next_rdata[`BIT_LOCKED]         = i_device_locked;
      end
      `ADDR_CRC_STATUS:
        next_rdata[2:0] = crc_state;
      default:
        next_rdata = `BYTE_ZERO;
    endcase
  end

  always @(posedge i_ref_clk)
  begin
    if (iface_rst)
    begin
      o_reg_rdata  <= `BYTE_ZERO;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= next_rdata;
    end
  end

endmodule
